// ### core/rcs_rx_client.sv
`timescale 1ns/100ps
// Overview of operation
// - The three-bit control frame type is meaningful only on end-of-packet beats, aligned.
// - Bit 0 marks a delivered standard pause frame.
// - In standard mode with pause forwarding off, bit 0 stays 0.
// - Bit 1 marks a delivered priority flow control frame.
// - In priority mode with pause forwarding off, bit 1 stays 0.
// - Bit 2 marks any other control frame.
// - The valid strobe is high only when the data bus holds valid contents.
// - All client signals are timed on the 312.5 MHz receive MAC clock.
// - Payload bytes carry control flag 0 and packet data; here non-start beats pass i_in_ctl unchanged.
// - In preamble pass-through the start byte has flag 1, the next seven bytes flag 0.
// - The external transmit clock option selects the extra clock input for the TX MAC; here it only drives o_clk_txmac_sel, and o_clk_txmac stays 0.

// Small synchronous fifo of flip-flops
module rcs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Write side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // Read side
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             do_wr, do_rd;

  // Pointer arithmetic with wrap
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Next pointers and occupancy
  always_comb
  begin
    do_wr    = i_wr_valid && (cnt_reg != (AW+1)'(DEPTH));
    do_rd    = i_rd_ready && (cnt_reg != '0);
    wp_next  = do_wr ? bump(wp_reg) : wp_reg;
    rp_next  = do_rd ? bump(rp_reg) : rp_reg;
    cnt_next = cnt_reg;
    if (do_wr && !do_rd)
    begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end
    else if (!do_wr && do_rd)
    begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
  end

  // Pointer registers
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
    begin
      mem_reg[wp_reg] <= i_wr_data;
    end
  end

  assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data  = mem_reg[rp_reg];
endmodule // rcs_fifo

// Receive client output stage with control frame status
module rcs_rx_client
  import rcs_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset; i_clk is the receive MAC clock
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // Configuration straps
  input  wire logic [1:0]           i_fc_mode,
  input  wire logic                 i_pause_fwd,
  input  wire logic                 i_preamble_pass,
  input  wire logic                 i_external_tx_clock_option,
  // TX MAC clock sources
  input  wire logic                 i_clk_txmac_pll,
  input  wire logic                 i_clk_txmac_in,
  output logic                      o_clk_txmac_sel,
  // Parsed receive stream from the MAC core
  input  wire logic                 i_in_valid,
  input  wire logic [LANES*8-1:0]   i_in_data,
  input  wire logic [LANES-1:0]     i_in_ctl,
  input  wire logic                 i_in_sop,
  input  wire logic                 i_in_eop,
  input  wire logic [3:0]           i_in_ftype,
  output logic                      o_in_ready,
  // Client stream and TX MAC clock output
  input  wire logic                 i_dout_ready,
  output logic                      o_dout_valid,
  output logic [LANES*8-1:0]        o_dout_d,
  output logic [LANES-1:0]          o_dout_c,
  output logic                      o_dout_sop,
  output logic                      o_dout_eop,
  output logic [STAT_W-1:0]         o_rx_status,
  output logic                      o_clk_txmac
);
  rcs_beat_t         beat_in, fifo_out;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic              fifo_rd_valid, take, in_take;
  logic [CW-1:0]     occ_reg, occ_next;
  logic [2:0]        status;
  logic [LANES-1:0]  ctl;
  rcs_beat_t         out_reg, out_next;
  logic              vld_reg, vld_next;
  logic              rdy_reg, rdy_next;
  logic              sel_reg, sel_next;
  logic [1:0]        sel_sync_reg;

  // Status bits, evaluated for eop beats only
  always_comb
  begin
    status = STAT_RST;
    if (i_in_eop)
    begin
      status[STAT_STD_PAUSE_BIT] = (i_in_ftype == RCS_FT_STD)
        && !((i_fc_mode == RCS_FC_STD) && !i_pause_fwd);
      status[STAT_PFC_BIT]       = (i_in_ftype == RCS_FT_PFC)
        && !((i_fc_mode == RCS_FC_PFC) && !i_pause_fwd);
      status[STAT_OTHER_BIT]     = (i_in_ftype == RCS_FT_OTHER);
      if (i_in_ftype == RCS_FT_DATA)
      begin
        status = STAT_RST;
      end
    end
  end

  // Per-byte control flags for start of packet
  always_comb
  begin
    ctl = i_in_ctl;
    if (i_in_sop && i_preamble_pass)
    begin
      ctl[PRE_BYTES-1:0]  = '0;
      ctl[START_BYTE]     = 1'b1;
    end
    else if (i_in_sop)
    begin
      ctl = '0;
    end
  end

  assign beat_in = '{data: i_in_data, ctl: ctl, sop: i_in_sop,
                     eop: i_in_eop, status: status};

  rcs_fifo #(
    .WIDTH ($bits(rcs_beat_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_valid (in_take),
    .i_wr_data  (beat_in),
    .o_wr_ready (),
    .o_rd_valid (fifo_rd_valid),
    .o_rd_data  (fifo_out),
    .i_rd_ready (take)
  );

  // Output register pops when empty or accepted
  assign take = fifo_rd_valid && (!vld_reg || i_dout_ready);

  always_comb
  begin
    out_next = out_reg;
    vld_next = vld_reg && !i_dout_ready;
    if (take)
    begin
      out_next = fifo_out;
      vld_next = 1'b1;
    end
    // Occupancy mirror keeps the input ready a plain flop
    in_take  = i_in_valid && rdy_reg;
    occ_next = occ_reg;
    if (in_take && !take)
    begin
      occ_next = CW'(occ_reg + 1'b1);
    end
    else if (!in_take && take)
    begin
      occ_next = CW'(occ_reg - 1'b1);
    end
    rdy_next = (occ_next != CW'(DEPTH));
    sel_next = sel_sync_reg[1];
  end

  // Output and strap registers
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      out_reg      <= '0;
      vld_reg      <= 1'b0;
      rdy_reg      <= 1'b0;
      occ_reg      <= '0;
      sel_reg      <= 1'b0;
      sel_sync_reg <= 2'h0;
    end
    else
    begin
      out_reg      <= out_next;
      vld_reg      <= vld_next;
      rdy_reg      <= rdy_next;
      occ_reg      <= occ_next;
      sel_reg      <= sel_next;
      sel_sync_reg <= {sel_sync_reg[0], i_external_tx_clock_option};
    end
  end

  // TX MAC clock output, held at 0 in reset and after; no clock mux here
  always_ff @(posedge i_clk_txmac_pll or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_clk_txmac <= 1'b0;
    end
    else
    begin
      o_clk_txmac <= 1'b0;
    end
  end

  assign o_in_ready      = rdy_reg;
  assign o_dout_valid    = vld_reg;
  assign o_dout_d        = out_reg.data;
  assign o_dout_c        = out_reg.ctl;
  assign o_dout_sop      = out_reg.sop;
  assign o_dout_eop      = out_reg.eop;
  assign o_rx_status     = out_reg.status;
  assign o_clk_txmac_sel = sel_reg;
endmodule // rcs_rx_client

// ### include/rcs_pkg.sv
package rcs_pkg;
  // Control frame type bit positions
  localparam int unsigned STAT_STD_PAUSE_BIT = 0;
  localparam int unsigned STAT_PFC_BIT       = 1;
  localparam int unsigned STAT_OTHER_BIT     = 2;
  localparam int unsigned STAT_W             = 3;
  // Byte lanes and fifo sizing
  localparam int unsigned LANES        = 32;
  localparam int unsigned FIFO_DEPTH   = 8;
  // Reset values
  localparam logic [2:0]  STAT_RST     = 3'h0;
  // Preamble pass-through: one start byte, six preamble bytes, one SFD
  localparam int unsigned PRE_BYTES    = 8;
  localparam int unsigned START_BYTE   = 0;
  // Clock figures
  localparam real         MAC_CLK_MHZ  = 312.5;
  localparam real         SYS_CLK_MHZ  = 100.0;

  // Frame type classification from the parser
  typedef enum logic [3:0]
  {
    RCS_FT_DATA  = 4'h1,
    RCS_FT_STD   = 4'h2,
    RCS_FT_PFC   = 4'h4,
    RCS_FT_OTHER = 4'h8
  } rcs_ftype_t;

  // Flow control mode
  typedef enum logic [1:0]
  {
    RCS_FC_NONE = 2'h0,
    RCS_FC_STD  = 2'h1,
    RCS_FC_PFC  = 2'h2
  } rcs_fcmode_t;

  // One beat of the client stream
  typedef struct packed
  {
    logic [LANES*8-1:0] data;
    logic [LANES-1:0]   ctl;
    logic               sop;
    logic               eop;
    logic [STAT_W-1:0]  status;
  } rcs_beat_t;
endpackage

// ### tb/rcs_client_model.sv
`timescale 1ns/100ps
// Client sink that can stall
module rcs_client_model
  import rcs_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  // Stream
  input  wire logic      i_stall,
  input  wire logic      i_valid,
  input  wire rcs_beat_t i_beat,
  output logic           o_ready
);
  logic [20:0] q[$];
  // Ready follows the stall request
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      o_ready <= 1'b0;
    else
      o_ready <= !i_stall;
  // Gap beats are ignored
  always @(posedge i_clk)
    if (i_valid && o_ready)
      q.push_back({i_beat.status, i_beat.ctl[7:0], i_beat.data[7:0], i_beat.sop, i_beat.eop});
endmodule // rcs_client_model

// ### tb/rcs_rx_client_assertions.sv
`timescale 1ns/100ps
// Client stream and TX MAC clock select checks
module rcs_chk
  import rcs_pkg::*;
(
  // Clock, reset and straps
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic [1:0] i_fc_mode,
  input wire logic       i_pause_fwd,
  input wire logic       i_preamble_pass,
  input wire logic       i_external_tx_clock_option,
  input wire logic       o_clk_txmac_sel,
  // Client stream
  input wire logic       i_dout_ready,
  input wire logic       o_dout_valid,
  input wire logic [LANES-1:0] o_dout_c,
  input wire logic       o_dout_sop,
  input wire logic       o_dout_eop,
  input wire logic [2:0] o_rx_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_eop;
    o_dout_valid && !o_dout_eop |-> o_rx_status == 3'h0;
  endproperty
  a_eop: assert property (p_eop) else $error("status off eop");
  property p_std;
    o_dout_valid && i_fc_mode == 2'h1 && !i_pause_fwd |-> !o_rx_status[0];
  endproperty
  a_std: assert property (p_std) else $error("pause bit set");
  property p_pfc;
    o_dout_valid && i_fc_mode == 2'h2 && !i_pause_fwd |-> !o_rx_status[1];
  endproperty
  a_pfc: assert property (p_pfc) else $error("pfc bit set");
  property p_one;
    o_dout_valid |-> $onehot0(o_rx_status);
  endproperty
  a_one: assert property (p_one) else $error("two types");
  property p_pre;
    o_dout_valid && o_dout_sop && i_preamble_pass |-> o_dout_c[7:0] == 8'h01;
  endproperty
  a_pre: assert property (p_pre) else $error("start flag");
  property p_hold;
    o_dout_valid && !i_dout_ready |=> o_dout_valid && $stable(o_dout_c);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");
  property p_son;
    i_external_tx_clock_option [*4] |-> o_clk_txmac_sel;
  endproperty
  a_son: assert property (p_son) else $error("select on");
  property p_soff;
    !i_external_tx_clock_option [*4] |-> !o_clk_txmac_sel;
  endproperty
  a_soff: assert property (p_soff) else $error("select off");
endmodule // rcs_chk

bind rcs_rx_client rcs_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fc_mode(i_fc_mode),
  .i_pause_fwd(i_pause_fwd), .i_preamble_pass(i_preamble_pass), .o_dout_c(o_dout_c),
  .i_external_tx_clock_option(i_external_tx_clock_option), .o_clk_txmac_sel(o_clk_txmac_sel),
  .i_dout_ready(i_dout_ready), .o_dout_valid(o_dout_valid), .o_dout_sop(o_dout_sop),
  .o_dout_eop(o_dout_eop), .o_rx_status(o_rx_status));

// ### tb/rcs_rx_client_test.sv
`timescale 1ns/100ps
// Bench for the client stage
module rcs_rx_client_test;
  import rcs_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, fwd = 1'b1, pass = 1'b0, opt = 1'b0;
  logic [1:0] i_fc_mode = 2'h0;
  logic       iv = 1'b0, stall = 1'b0, in_rdy, drdy, ov, sel;
  logic [3:0] ift = 4'h1;
  rcs_beat_t  ib = '0;
  wire rcs_beat_t ob;
  int         n_fail = 0, n_checks = 0;
  localparam int DEPTH_T = FIFO_DEPTH;
  rcs_rx_client dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fc_mode(i_fc_mode),
    .i_pause_fwd(fwd), .i_preamble_pass(pass), .i_external_tx_clock_option(opt),
    .i_clk_txmac_pll(i_clk), .i_clk_txmac_in(i_clk), .o_clk_txmac_sel(sel),
    .i_in_valid(iv), .i_in_data(ib.data), .i_in_ctl(ib.ctl), .i_in_sop(ib.sop),
    .i_in_eop(ib.eop), .i_in_ftype(ift), .o_in_ready(in_rdy), .i_dout_ready(drdy),
    .o_dout_valid(ov), .o_dout_d(ob.data), .o_dout_c(ob.ctl), .o_dout_sop(ob.sop),
    .o_dout_eop(ob.eop), .o_rx_status(ob.status), .o_clk_txmac());
  rcs_client_model cl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_stall(stall),
    .i_valid(ov), .i_beat(ob), .o_ready(drdy));
  // Clock
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [3:0] ft, input logic s, e, input logic [7:0] b);
    int n;
    ib <= '{data: {LANES{b}}, ctl: {LANES{s}}, sop: s, eop: e, status: 3'h0};
    ift <= ft;
    iv <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (!in_rdy && n < 50);
    // A beat never taken counts as a mismatch
    if (!in_rdy)
    begin
      n_fail++;
    end
  endtask
  task automatic idle();
    iv <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic take(input logic [20:0] e);
    repeat (60) if (cl.q.size() == 0) @(posedge i_clk);
    chk(cl.q.pop_front(), e);
  endtask
  task automatic t_types();
    for (int k = 0; k < 4; k++)
    begin
      send(4'h1 << k, 1'b1, 1'b1, 8'hA0 + k[7:0]);
      idle();
      take({3'(k > 0 ? 1 << (k - 1) : 0), 8'h00, 8'hA0 + k[7:0], 2'h3});
    end
  endtask
  task automatic t_off();
    fwd <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      i_fc_mode <= k[1] ? 2'h2 : 2'h1;
      send(k[0] ? 4'h4 : 4'h2, 1'b1, 1'b1, 8'h5A);
      idle();
      take({3'(k == 1 ? 2 : k == 2 ? 1 : 0), 8'h00, 8'h5A, 2'h3});
    end
    fwd <= 1'b1;
  endtask
  task automatic t_pre();
    pass <= 1'b1;
    send(4'h8, 1'b1, 1'b0, 8'h55);
    send(4'h8, 1'b0, 1'b0, 8'hD5);
    idle();
    send(4'h8, 1'b0, 1'b1, 8'h33);
    idle();
    take({3'h0, 8'h01, 8'h55, 2'h2});
    take({3'h0, 8'h00, 8'hD5, 2'h0});
    take({3'h4, 8'h00, 8'h33, 2'h1});
    pass <= 1'b0;
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    stall <= 1'b1;
    ift   <= 4'h1;
    repeat (2) @(posedge i_clk);
    for (int k = 0; k < 20; k++)
    begin
      ib <= '{data: {LANES{n[7:0]}}, ctl: 32'h0, sop: 1'b1, eop: 1'b1, status: 3'h0};
      iv <= 1'b1;
      @(posedge i_clk);
      if (in_rdy) n++;
    end
    idle();
    chk(in_rdy, 0);
    chk(n >= DEPTH_T, 1);
    stall <= 1'b0;
    for (int k = 0; k < n; k++) take({3'h0, 8'h00, k[7:0], 2'h3});
  endtask
  task automatic t_txclk();
    opt <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(sel, 1);
    opt <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(sel, 0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_types();
    t_off();
    t_pre();
    t_fill();
    t_txclk();
    end_of_test();
  end
endmodule // rcs_rx_client_test
